/* baud_gen.sv */
// ****************************************************************
// Shared constants of the composite port line timing
// ****************************************************************
package line_timing_pkg;

    localparam int unsigned REF_HZ         = 20_000_000;
    localparam int unsigned REF_PERIOD_NS  = 50;
    localparam int unsigned CHAR_BITS      = 8;
    localparam int unsigned BIT_CNT_W      = 3;
    localparam int unsigned NUM_RATES      = 8;
    localparam int unsigned SEL_W          = 3;
    localparam int unsigned DIV_W          = 24;
    localparam logic [7:0]  FLAG_CHAR      = 8'h7e;
    localparam logic [2:0]  LAST_BIT       = 3'h7;
    localparam logic        SWITCH_CLOSED  = 1'b1;

    typedef enum logic {
        RX_HUNT   = 1'b0,
        RX_LOCKED = 1'b1
    } rx_state_e;

    // Half a baud period in reference clock cycles, rounded down, never zero
    function automatic logic [DIV_W-1:0] half_div(input int unsigned rate);
        int unsigned d;
        d = (rate == 0) ? 1 : REF_HZ / (2 * rate);
        if (d == 0) begin
            d = 1;
        end
        return d[DIV_W-1:0];
    endfunction

endpackage

`timescale 1ns/1ps

// ****************************************************************
// Baud generator: square wave at the baud rate plus edge ticks
// ****************************************************************
module baud_gen #(
    parameter int unsigned DIV_W = line_timing_pkg::DIV_W
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [DIV_W-1:0] half_div_i,
    output logic                  baud_clk_o,
    output logic                  rise_o,
    output logic                  fall_o
);

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic             next_baud_clk;
    logic             next_rise;
    logic             next_fall;

    always_comb begin
        next_cnt      = cnt + 1'b1;
        next_baud_clk = baud_clk_o;
        next_rise     = 1'b0;
        next_fall     = 1'b0;
        // A shrinking divisor must not strand the counter above it
        if (next_cnt >= half_div_i) begin
            next_cnt      = '0;
            next_baud_clk = ~baud_clk_o;
            next_rise     = ~baud_clk_o;
            next_fall     = baud_clk_o;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt        <= '0;
            baud_clk_o <= 1'b0;
            rise_o     <= 1'b0;
            fall_o     <= 1'b0;
        end else begin
            cnt        <= next_cnt;
            baud_clk_o <= next_baud_clk;
            rise_o     <= next_rise;
            fall_o     <= next_fall;
        end
    end

endmodule

/* composite_port.sv */

`timescale 1ns/1ps

module composite_port #(
    parameter int unsigned BAUD_RATE [line_timing_pkg::NUM_RATES] =
        '{9600, 4800, 2400, 1200, 600, 300, 150, 110}
) (
    input  wire logic       REF_CLK_I,
    input  wire logic       RSTN_I,
    input  wire logic       RX_LINK_CLK_I,
    input  wire logic       TX_LINK_CLK_I,
    input  wire logic       RXD_I,
    input  wire logic       CTS_I,
    input  wire logic       DSR_I,
    input  wire logic       CLOCK_SOURCE_SWITCH_I,
    input  wire logic [2:0] BAUD_SELECT_I,
    input  wire logic [7:0] TX_DATA_I,
    input  wire logic       TX_VALID_I,
    output logic            TX_READY_O,
    output logic            TXD_O,
    output logic            RTS_O,
    output logic            DTR_O,
    output logic            CLK_EXT_O,
    output logic [7:0]      RX_DATA_O,
    output logic            RX_VALID_O,
    output logic            RX_IS_FLAG_O
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic       sw_meta;
    logic       sw_sync;
    logic [2:0] sel_meta;
    logic [2:0] sel_sync;
    logic       txc_meta;
    logic       txc_sync;
    logic       txc_prev;
    logic       rxd_meta;
    logic       rxd_sync;
    logic       tgl_meta;
    logic       tgl_sync;
    logic       tgl_prev;

    // Link domain flops, written only on the modem receive clock
    logic       link_bit;
    logic       link_tgl;

    // Modem status inputs stay unread on purpose
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sw_meta  <= 1'b0;
            sw_sync  <= 1'b0;
            sel_meta <= '0;
            sel_sync <= '0;
            txc_meta <= 1'b0;
            txc_sync <= 1'b0;
            txc_prev <= 1'b0;
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            tgl_meta <= 1'b0;
            tgl_sync <= 1'b0;
            tgl_prev <= 1'b0;
        end else begin
            sw_meta  <= CLOCK_SOURCE_SWITCH_I;
            sw_sync  <= sw_meta;
            sel_meta <= BAUD_SELECT_I;
            sel_sync <= sel_meta;
            txc_meta <= TX_LINK_CLK_I;
            txc_sync <= txc_meta;
            txc_prev <= txc_sync;
            rxd_meta <= RXD_I;
            rxd_sync <= rxd_meta;
            tgl_meta <= link_tgl;
            tgl_sync <= tgl_meta;
            tgl_prev <= tgl_sync;
        end
    end

    // ****************************************************************
    // Receive link domain
    // ****************************************************************
    // Bit and toggle change together; the bit is read only after the
    // toggle has crossed, and holds until the next modem receive clock edge after that
    always_ff @(posedge RX_LINK_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            link_bit <= 1'b1;
            link_tgl <= 1'b0;
        end else begin
            link_bit <= RXD_I;
            link_tgl <= ~link_tgl;
        end
    end

    // ****************************************************************
    // Baud generator and timing source selection
    // ****************************************************************
    logic                              ext_mode;
    logic [line_timing_pkg::DIV_W-1:0] cur_div;
    logic                              bg_rise;
    logic                              bg_fall;
    logic                              tx_tick;
    logic                              rx_tick;
    logic                              rx_bit;

    assign ext_mode = (sw_sync == line_timing_pkg::SWITCH_CLOSED);
    assign cur_div  = line_timing_pkg::half_div(BAUD_RATE[sel_sync]);

    baud_gen #(
        .DIV_W (line_timing_pkg::DIV_W)
    ) u_baud_gen (
        .clk_i      (REF_CLK_I),
        .rstn_i     (RSTN_I),
        .half_div_i (cur_div),
        .baud_clk_o (CLK_EXT_O),
        .rise_o     (bg_rise),
        .fall_o     (bg_fall)
    );

    // Transmit bits change on the falling edge, receive samples on rising
    assign tx_tick = ext_mode ? (txc_prev & ~txc_sync) : bg_fall;
    assign rx_tick = ext_mode ? (tgl_sync ^ tgl_prev) : bg_rise;
    assign rx_bit  = ext_mode ? link_bit : rxd_sync;

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    logic [7:0] hold;
    logic       hold_full;
    logic [7:0] tx_shift;
    logic [2:0] tx_cnt;
    logic [7:0] next_hold;
    logic       next_hold_full;
    logic [7:0] next_tx_shift;
    logic [2:0] next_tx_cnt;
    logic       next_txd;
    logic [7:0] tx_char;

    always_comb begin
        next_hold      = hold;
        next_hold_full = hold_full;
        next_tx_shift  = tx_shift;
        next_tx_cnt    = tx_cnt;
        next_txd       = TXD_O;
        tx_char        = hold_full ? hold : line_timing_pkg::FLAG_CHAR;
        if (tx_tick) begin
            if (tx_cnt == '0) begin
                next_txd       = tx_char[0];
                next_tx_shift  = {1'b0, tx_char[7:1]};
                next_tx_cnt    = line_timing_pkg::LAST_BIT;
                next_hold_full = 1'b0;
            end else begin
                next_txd      = tx_shift[0];
                next_tx_shift = {1'b0, tx_shift[7:1]};
                next_tx_cnt   = tx_cnt - 1'b1;
            end
        end
        // Ready is low while full, so a take never meets a full buffer
        if (TX_VALID_I && TX_READY_O) begin
            next_hold      = TX_DATA_I;
            next_hold_full = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            hold       <= '0;
            hold_full  <= 1'b0;
            tx_shift   <= '0;
            tx_cnt     <= '0;
            TXD_O      <= 1'b1;
            TX_READY_O <= 1'b0;
            RTS_O      <= 1'b0;
            DTR_O      <= 1'b0;
        end else begin
            hold       <= next_hold;
            hold_full  <= next_hold_full;
            tx_shift   <= next_tx_shift;
            tx_cnt     <= next_tx_cnt;
            TXD_O      <= next_txd;
            TX_READY_O <= ~next_hold_full;
            RTS_O      <= 1'b0;
            DTR_O      <= 1'b0;
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    line_timing_pkg::rx_state_e rx_state;
    line_timing_pkg::rx_state_e next_rx_state;
    logic [7:0]                 rx_win;
    logic [2:0]                 rx_cnt;
    logic [7:0]                 next_rx_win;
    logic [2:0]                 next_rx_cnt;
    logic [7:0]                 next_rx_data;
    logic                       next_rx_valid;
    logic                       next_rx_flag;

    // Character alignment comes from the first flag; loss of alignment
    // is left to the framing layer above
    always_comb begin
        next_rx_state = rx_state;
        next_rx_win   = rx_win;
        next_rx_cnt   = rx_cnt;
        next_rx_data  = RX_DATA_O;
        next_rx_valid = 1'b0;
        next_rx_flag  = RX_IS_FLAG_O;
        if (rx_tick) begin
            next_rx_win = {rx_bit, rx_win[7:1]};
            unique case (rx_state)
                line_timing_pkg::RX_HUNT: begin
                    if (next_rx_win == line_timing_pkg::FLAG_CHAR) begin
                        next_rx_state = line_timing_pkg::RX_LOCKED;
                        next_rx_cnt   = '0;
                        next_rx_data  = next_rx_win;
                        next_rx_valid = 1'b1;
                        next_rx_flag  = 1'b1;
                    end
                end
                line_timing_pkg::RX_LOCKED: begin
                    next_rx_cnt = rx_cnt + 1'b1;
                    if (rx_cnt == line_timing_pkg::LAST_BIT) begin
                        next_rx_data  = next_rx_win;
                        next_rx_valid = 1'b1;
                        next_rx_flag  = (next_rx_win == line_timing_pkg::FLAG_CHAR);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rx_state     <= line_timing_pkg::RX_HUNT;
            rx_win       <= '0;
            rx_cnt       <= '0;
            RX_DATA_O    <= '0;
            RX_VALID_O   <= 1'b0;
            RX_IS_FLAG_O <= 1'b0;
        end else begin
            rx_state     <= next_rx_state;
            rx_win       <= next_rx_win;
            rx_cnt       <= next_rx_cnt;
            RX_DATA_O    <= next_rx_data;
            RX_VALID_O   <= next_rx_valid;
            RX_IS_FLAG_O <= next_rx_flag;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [line_timing_pkg::DIV_W-1:0] baud_stable_cnt;

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            baud_stable_cnt <= '0;
        end else if (CLK_EXT_O != $past(CLK_EXT_O)) begin
            baud_stable_cnt <= '0;
        end else begin
            baud_stable_cnt <= baud_stable_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);

    chk_flag_fill: assert property (
        tx_tick && tx_cnt == '0 && !hold_full
        |=> TXD_O == line_timing_pkg::FLAG_CHAR[0] && tx_cnt == line_timing_pkg::LAST_BIT
    ) else $error("flag not sent on idle line");

    chk_tx_data_bit: assert property (
        tx_tick && tx_cnt == '0 && hold_full |=> TXD_O == $past(hold[0]) && !hold_full
    ) else $error("held character not started");

    chk_tx_between: assert property (
        !tx_tick |=> $stable(TXD_O)
    ) else $error("transmit data moved without a bit edge");

    chk_int_tx_ignore: assert property (
        !ext_mode && $past(!ext_mode) && !bg_fall |=> $stable(TXD_O)
    ) else $error("transmit clock pin acted in internal mode");

    chk_int_rx_ignore: assert property (
        !ext_mode && $past(!ext_mode) && !bg_rise |=> $stable(rx_win)
    ) else $error("receive clock pin acted in internal mode");

    chk_ext_rx_clock: assert property (
        ext_mode && tgl_sync == tgl_prev |=> $stable(rx_win)
    ) else $error("receive sampled without modem clock");

    chk_rx_char: assert property (
        rx_state == line_timing_pkg::RX_LOCKED && rx_tick && rx_cnt == line_timing_pkg::LAST_BIT
        |=> RX_VALID_O ##1 !RX_VALID_O
    ) else $error("received character not presented");

    chk_modem_idle: assert property (
        !RTS_O && !DTR_O
    ) else $error("modem control output driven");

    chk_baud_running: assert property (
        $stable(cur_div) && $past($stable(cur_div)) |-> baud_stable_cnt < cur_div + 1'b1
    ) else $error("baud clock output stalled");

endmodule

/* composite_port_tb.sv */
`timescale 1ns/1ps

module composite_port_tb;
    localparam int unsigned RATES [8] = '{1000000, 500000, 9600, 4800, 2400, 1200, 600, 300};
    logic       ref_clk  = 1'b0;
    logic       rstn     = 1'b0;
    logic       rx_lclk;
    logic       tx_lclk;
    logic       rxd;
    logic       cts      = 1'b0;
    logic       dsr      = 1'b0;
    logic       sw       = 1'b0;
    logic [2:0] bsel     = 3'h1;
    logic [7:0] tx_data  = 8'h00;
    logic       tx_valid = 1'b0;
    logic       tx_ready;
    logic       txd;
    logic       rts;
    logic       dtr;
    logic       clk_ext;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_flag;
    int         num_errors = 0;
    int         checked    = 0;
    int         cycles     = 0;
    logic [7:0] rxq [$];
    logic       rxf [$];

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    composite_port #(.BAUD_RATE(RATES)) u_composite_port (
        .REF_CLK_I(ref_clk), .RSTN_I(rstn), .RX_LINK_CLK_I(rx_lclk),
        .TX_LINK_CLK_I(tx_lclk), .RXD_I(rxd), .CTS_I(cts), .DSR_I(dsr),
        .CLOCK_SOURCE_SWITCH_I(sw), .BAUD_SELECT_I(bsel), .TX_DATA_I(tx_data),
        .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .TXD_O(txd), .RTS_O(rts),
        .DTR_O(dtr), .CLK_EXT_O(clk_ext), .RX_DATA_O(rx_data),
        .RX_VALID_O(rx_valid), .RX_IS_FLAG_O(rx_flag));

    sync_modem u_sync_modem (.ext_i(sw), .clk_ext_i(clk_ext), .txd_i(txd),
        .tx_clk_o(tx_lclk), .rx_clk_o(rx_lclk), .rxd_o(rxd));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            $display("MISMATCH %0t %s", $time, msg);
            num_errors++;
        end
    endtask

    // Modem lines wiggle all the time; the block must not care
    always @(posedge ref_clk) begin
        cycles++;
        cts <= ~cts;
        dsr <= cycles[3];
        if (rx_valid === 1'b1) begin
            rxq.push_back(rx_data);
            rxf.push_back(rx_flag);
        end
        if (cycles == 20000) begin
            check(1'b0, "timeout");
            give_verdict();
        end
    end

    task automatic do_reset(input logic m);
        rstn <= 1'b0;
        sw   <= m;
        repeat (4) @(posedge ref_clk);
        u_sync_modem.locked = 1'b0;
        // All ones, so the first zero seen opens a real flag, not a stale one
        u_sync_modem.sh     = 8'hff;
        u_sync_modem.got.delete();
        rxq.delete();
        rxf.delete();
        rstn <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic send_tx(input logic [7:0] c);
        int n;
        n = 0;
        @(posedge ref_clk);
        tx_data  <= c;
        tx_valid <= 1'b1;
        @(posedge ref_clk);
        while (tx_ready !== 1'b1 && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        tx_valid <= 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_baud();
        int n;
        n = 0;
        while (!(clk_ext === 1'b0) && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        while (!(clk_ext === 1'b1) && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        n = 0;
        while (clk_ext === 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        while (clk_ext === 1'b0 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        check(n == 2 * (line_timing_pkg::REF_HZ / (2 * RATES[1])), "baud period");
        check(rts === 1'b0 && dtr === 1'b0, "rts dtr active");
    endtask

    // Two characters back to back, then flags again
    task automatic test_tx(input logic [7:0] a, input logic [7:0] b);
        int n;
        int i;
        n = 0;
        i = 0;
        u_sync_modem.got.delete();
        send_tx(a);
        send_tx(b);
        while (u_sync_modem.got.size() < 12 && n < 9000) begin
            @(posedge ref_clk);
            n++;
        end
        while (i < 8 && u_sync_modem.got[i] === 8'h7e) begin
            i++;
        end
        check(i < 8 && u_sync_modem.got[i] === a, "first char");
        check(u_sync_modem.got[i+1] === b, "second char");
        check(u_sync_modem.got[i+2] === 8'h7e && u_sync_modem.got[i+3] === 8'h7e, "fill");
    endtask

    task automatic test_rx(input logic [7:0] c);
        int n;
        int i;
        n = 0;
        i = 0;
        // Flags gathered by earlier scenarios would hide the character
        rxq.delete();
        rxf.delete();
        u_sync_modem.out_q.push_back(c);
        while (rxq.size() < 4 && n < 6000) begin
            @(posedge ref_clk);
            n++;
        end
        while (i < 3 && rxq[i] === 8'h7e) begin
            check(rxf[i] === 1'b1, "flag bit");
            i++;
        end
        check(i < 3 && rxq[i] === c && rxf[i] === 1'b0, "rx char");
    endtask

    initial begin
        do_reset(1'b0);
        test_baud();
        test_tx(8'ha5, 8'h5a);
        test_rx(8'h3c);
        do_reset(1'b1);
        test_baud();
        test_tx(8'h81, 8'h18);
        test_rx(8'hc3);
        give_verdict();
    end
endmodule

/* placeholder_end.sv */
`timescale 1ns/1ps

/* sync_modem.sv */
`timescale 1ns/1ps

// ****************************************************************
// Synchronous modem on the composite link
// ****************************************************************
module sync_modem (
    input  wire logic ext_i,
    input  wire logic clk_ext_i,
    input  wire logic txd_i,
    output logic      tx_clk_o,
    output logic      rx_clk_o,
    output logic      rxd_o
);
    logic       osc    = 1'b0;
    logic [6:0] div    = 7'h00;
    logic       lclk   = 1'b0;
    logic [7:0] sh     = 8'h00;
    logic [7:0] cur    = 8'h7e;
    logic [2:0] cnt    = 3'h0;
    logic [2:0] oix    = 3'h0;
    logic       locked = 1'b0;
    logic       line_bit = 1'b1;
    logic       bclk;
    logic [7:0] got [$];
    logic [7:0] out_q [$];

    // 12 ns base, divided so the slow bit clock survives the sync in the block
    initial begin
        #3.7;
        forever #6 osc = ~osc;
    end
    // Other rate in internal mode: the block must not follow it
    always @(posedge osc) begin
        div = (div == (ext_i ? 7'h27 : 7'h1b)) ? 7'h00 : div + 7'h01;
        if (div == 7'h00) begin
            lclk = ~lclk;
        end
    end
    assign tx_clk_o = lclk;
    assign rx_clk_o = lclk;
    assign bclk     = ext_i ? lclk : clk_ext_i;

    // Line data taken on rising edge, aligned on the first flag
    always @(posedge bclk) begin
        sh  = {txd_i, sh[7:1]};
        cnt = cnt + 3'h1;
        if (!locked && sh == 8'h7e) begin
            locked = 1'b1;
            cnt    = 3'h0;
        end else if (locked && cnt == 3'h0) begin
            got.push_back(sh);
        end
    end
    // Send data changes on falling edge, flags when nothing queued
    always @(negedge bclk) begin
        line_bit = cur[oix];
        oix   = oix + 3'h1;
        if (oix == 3'h0) begin
            cur = (out_q.size() > 0) ? out_q.pop_front() : 8'h7e;
        end
    end
    // One process owns the line bit; the port only follows it
    assign rxd_o = line_bit;
endmodule
